// ---- design/bit_rate_decode.sv ----
// Decoder from the coded bit-rate selector to a rate in kBd.
// Assumes the caller registers the result; this module is purely combinational.
`timescale 1ns/1ns
`default_nettype none

module bit_rate_decode
(
	// Coded selector.
	input wire logic [7:0] code_i,
	// Decoded rate and whether the code was one of the listed ones.
	output logic [10:0] kbd_o,
	output logic listed_o
);

	// Map each listed code; anything else, 0x87 included, falls back to 1000 kBd.
	always_comb
	begin
		listed_o = 1'b1;
		case (code_i)
			canopen_cfg_pkg::RATE_CODE_10K: kbd_o = canopen_cfg_pkg::KBD_10;
			canopen_cfg_pkg::RATE_CODE_20K: kbd_o = canopen_cfg_pkg::KBD_20;
			canopen_cfg_pkg::RATE_CODE_50K: kbd_o = canopen_cfg_pkg::KBD_50;
			canopen_cfg_pkg::RATE_CODE_125K: kbd_o = canopen_cfg_pkg::KBD_125;
			canopen_cfg_pkg::RATE_CODE_250K: kbd_o = canopen_cfg_pkg::KBD_250;
			canopen_cfg_pkg::RATE_CODE_500K: kbd_o = canopen_cfg_pkg::KBD_500;
			canopen_cfg_pkg::RATE_CODE_1000K: kbd_o = canopen_cfg_pkg::KBD_1000;
			default:
			begin
				// Unlisted codes still run the bus, at the fastest rate.
				kbd_o = canopen_cfg_pkg::KBD_1000;
				listed_o = 1'b0;
			end
		endcase
	end

endmodule // bit_rate_decode

`default_nettype wire

// ---- design/canopen_cfg_bank.sv ----
// Configuration-object bank: programming control and status, startup selector,
// coded bit-rate selector, and the startup part of the network-management states.
// Assumes the protocol engine presents object accesses on the same clock and that
// the programming engine drives the status words on the same clock.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Two RW control bytes, count two, reset zero
// - Two RO status words, count two, reset zero
// - Startup zero leaves network management Pre-Operational
// - Startup bit 3 enters Operational after init
// - Bit-rate selector presets to 0x88, 1000 kBd
// - Listed codes select 10 through 1000 kBd
// - Unlisted codes, 0x87 included, mean 1000 kBd
module canopen_cfg_bank
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Object-dictionary access port and its answer.
	input wire canopen_cfg_pkg::od_req_type req_i,
	output var canopen_cfg_pkg::od_rsp_type rsp_o,
	// Progress from the programming engine.
	input wire logic status_boot_load_i,
	input wire logic [31:0] status_boot_i,
	input wire logic status_script_load_i,
	input wire logic [31:0] status_script_i,
	// Initialization handshake from the controller.
	input wire logic init_done_i,
	input wire logic reinit_i,
	// Settings toward the rest of the controller.
	output logic [7:0] prog_ctrl_boot_o,
	output logic [7:0] prog_ctrl_script_o,
	output logic [31:0] startup_select_o,
	output var canopen_cfg_pkg::nmt_state_type nmt_state_o,
	output logic [7:0] bit_rate_code_o,
	output logic [10:0] bit_rate_kbd_o,
	output logic bit_rate_listed_o
);

	// Reset release synchroniser; only the second stage is used by the design.
	// The first stage may go metastable on a release, so nothing else reads it.
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;

	// The reset takes effect at once but leaves only after two clean edges,
	// so no flop sees a release that lands close to an edge.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_n = rst_sync_reg;

	// True when an access names the given index and subindex.
	// Used for every object, so all entries decode the same way.
	function automatic logic match_obj(input canopen_cfg_pkg::od_req_type r,
		input logic [15:0] idx, input logic [7:0] sub);
		match_obj = (r.index == idx) && (r.subindex == sub);
	endfunction

	// Stored objects. Each next value defaults to its own register, so an
	// access to one object can never disturb another.
	logic [7:0] ctrl_boot_reg, ctrl_boot_next;
	logic [7:0] ctrl_script_reg, ctrl_script_next;
	logic [31:0] status_boot_reg, status_boot_next;
	logic [31:0] status_script_reg, status_script_next;
	logic [31:0] startup_reg, startup_next;
	logic [7:0] rate_code_reg, rate_code_next;

	// Answer registers. The answer stands for exactly one cycle after the
	// taking edge; the protocol engine must take it then, as nothing holds it.
	canopen_cfg_pkg::od_rsp_type rsp_reg, rsp_next;

	// Decoded rate, registered so the outputs come from flops.
	logic [10:0] kbd_dec;
	logic listed_dec;
	logic [10:0] kbd_reg;
	logic listed_reg;

	// Network-management startup state.
	canopen_cfg_pkg::nmt_state_type nmt_reg, nmt_next;

	// Access decoding and the next values of every stored object.
	// An access that matches nothing here is still answered, with an abort,
	// so the protocol engine never waits on an object this bank does not own.
	always_comb
	begin
		ctrl_boot_next = ctrl_boot_reg;
		ctrl_script_next = ctrl_script_reg;
		startup_next = startup_reg;
		rate_code_next = rate_code_reg;
		status_boot_next = status_boot_reg;
		status_script_next = status_script_reg;
		// The answer is zero unless a request is taken this cycle.
		rsp_next = '0;

		// Status words follow the programming engine, never the bus.
		// A load and a read in one cycle are safe: the read shows the old word
		// and the next read the new one.
		if (status_boot_load_i)
		begin
			status_boot_next = status_boot_i;
		end
		if (status_script_load_i)
		begin
			status_script_next = status_script_i;
		end

		if (req_i.valid)
		begin
			rsp_next.ack = 1'b1;
			// Entry counts of both arrays: fixed, so writes abort.
			if (match_obj(req_i, canopen_cfg_pkg::IDX_PROG_CTRL, canopen_cfg_pkg::SUB_COUNT)
				|| match_obj(req_i, canopen_cfg_pkg::IDX_PROG_STATUS,
				canopen_cfg_pkg::SUB_COUNT))
			begin
				rsp_next.rdata = {24'h000000, canopen_cfg_pkg::ENTRY_COUNT_VALUE};
				rsp_next.abort = req_i.write;
			end
			// Boot area control byte.
			else if (match_obj(req_i, canopen_cfg_pkg::IDX_PROG_CTRL,
				canopen_cfg_pkg::SUB_BOOT_AREA))
			begin
				rsp_next.rdata = {24'h000000, ctrl_boot_reg};
				if (req_i.write)
				begin
					ctrl_boot_next = req_i.wdata[7:0];
				end
			end
			// User script area control byte.
			else if (match_obj(req_i, canopen_cfg_pkg::IDX_PROG_CTRL,
				canopen_cfg_pkg::SUB_SCRIPT_AREA))
			begin
				rsp_next.rdata = {24'h000000, ctrl_script_reg};
				if (req_i.write)
				begin
					ctrl_script_next = req_i.wdata[7:0];
				end
			end
			// Boot area status: read only.
			else if (match_obj(req_i, canopen_cfg_pkg::IDX_PROG_STATUS,
				canopen_cfg_pkg::SUB_BOOT_AREA))
			begin
				rsp_next.rdata = status_boot_reg;
				rsp_next.abort = req_i.write;
			end
			// Script area status: read only.
			else if (match_obj(req_i, canopen_cfg_pkg::IDX_PROG_STATUS,
				canopen_cfg_pkg::SUB_SCRIPT_AREA))
			begin
				rsp_next.rdata = status_script_reg;
				rsp_next.abort = req_i.write;
			end
			// Startup selector, a plain variable at subindex zero.
			else if (match_obj(req_i, canopen_cfg_pkg::IDX_STARTUP, canopen_cfg_pkg::SUB_COUNT))
			begin
				rsp_next.rdata = startup_reg;
				if (req_i.write)
				begin
					startup_next = req_i.wdata;
				end
			end
			// Bit-rate selector; any byte is stored, decoding handles odd codes.
			else if (match_obj(req_i, canopen_cfg_pkg::IDX_BIT_RATE, canopen_cfg_pkg::SUB_COUNT))
			begin
				rsp_next.rdata = {24'h000000, rate_code_reg};
				if (req_i.write)
				begin
					rate_code_next = req_i.wdata[7:0];
				end
			end
			// Anything else is not in this bank.
			// That includes nonzero subindices of the two plain variables.
			else
			begin
				rsp_next.abort = 1'b1;
			end
		end
	end

	// Register the objects and the answer.
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_boot_reg <= canopen_cfg_pkg::PROG_CTRL_RESET;
			ctrl_script_reg <= canopen_cfg_pkg::PROG_CTRL_RESET;
			status_boot_reg <= canopen_cfg_pkg::PROG_STATUS_RESET;
			status_script_reg <= canopen_cfg_pkg::PROG_STATUS_RESET;
			startup_reg <= canopen_cfg_pkg::STARTUP_RESET;
			rate_code_reg <= canopen_cfg_pkg::BIT_RATE_RESET;
			rsp_reg <= '0;
		end
		else
		begin
			ctrl_boot_reg <= ctrl_boot_next;
			ctrl_script_reg <= ctrl_script_next;
			status_boot_reg <= status_boot_next;
			status_script_reg <= status_script_next;
			startup_reg <= startup_next;
			rate_code_reg <= rate_code_next;
			rsp_reg <= rsp_next;
		end
	end

	// Rate decoder works on the stored code. Decoding lives in its own module
	// so the table can be changed without touching the access logic.
	bit_rate_decode u_rate
	(
		.code_i(rate_code_reg),
		.kbd_o(kbd_dec),
		.listed_o(listed_dec)
	);

	// The decoded rate lags the stored code by one cycle; that keeps the
	// rate outputs glitch free at the cost of a single cycle of latency.
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			kbd_reg <= canopen_cfg_pkg::KBD_1000;
			listed_reg <= 1'b1;
		end
		else
		begin
			kbd_reg <= kbd_dec;
			listed_reg <= listed_dec;
		end
	end

	// Startup state: after initialization, the selector picks the first state.
	// The choice is made once per pass through INIT, so a later write to the
	// selector only counts after a new initialization; a write in the same
	// cycle as the done pulse is too late for that pass.
	always_comb
	begin
		nmt_next = nmt_reg;
		case (nmt_reg)
			canopen_cfg_pkg::NMT_INIT:
			begin
				if (init_done_i)
				begin
					if (startup_reg[canopen_cfg_pkg::STARTUP_AUTO_OPER_BIT])
					begin
						nmt_next = canopen_cfg_pkg::NMT_OPERATIONAL;
					end
					else
					begin
						nmt_next = canopen_cfg_pkg::NMT_PRE_OPERATIONAL;
					end
				end
			end
			default:
			begin
				// A new initialization starts the choice over.
				// A reinit pulse while in INIT is ignored; the pass is already open.
				if (reinit_i)
				begin
					nmt_next = canopen_cfg_pkg::NMT_INIT;
				end
			end
		endcase
	end

	// Register the startup state. Reset always lands in INIT, whatever the
	// selector held, because the state register itself is reset straight to INIT.
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nmt_reg <= canopen_cfg_pkg::NMT_INIT;
		end
		else
		begin
			nmt_reg <= nmt_next;
		end
	end

	// Outputs, all straight from flops, so downstream logic sees no decode
	// glitches and every setting changes on a clock edge, or at once when reset asserts.
	assign rsp_o = rsp_reg;
	assign prog_ctrl_boot_o = ctrl_boot_reg;
	assign prog_ctrl_script_o = ctrl_script_reg;
	assign startup_select_o = startup_reg;
	assign nmt_state_o = nmt_reg;
	assign bit_rate_code_o = rate_code_reg;
	assign bit_rate_kbd_o = kbd_reg;
	assign bit_rate_listed_o = listed_reg;

endmodule // canopen_cfg_bank

`default_nettype wire

// ---- design/canopen_cfg_pkg.sv ----
// Constants, carriers and state types for the boot and bus configuration bank.
// Assumes a single 50 MHz controller clock shared by every user of this package.
package canopen_cfg_pkg;

	// Object indices of the bank.
	localparam logic [15:0] IDX_PROG_CTRL = 16'h1f51;
	localparam logic [15:0] IDX_PROG_STATUS = 16'h1f57;
	localparam logic [15:0] IDX_STARTUP = 16'h1f80;
	localparam logic [15:0] IDX_BIT_RATE = 16'h2005;

	// Subindices inside the array objects.
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_BOOT_AREA = 8'h01;
	localparam logic [7:0] SUB_SCRIPT_AREA = 8'h02;

	// Reset and fixed values.
	localparam logic [7:0] ENTRY_COUNT_VALUE = 8'h02;
	localparam logic [7:0] PROG_CTRL_RESET = 8'h00;
	localparam logic [31:0] PROG_STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] STARTUP_RESET = 32'h0000_0000;
	localparam logic [7:0] BIT_RATE_RESET = 8'h88;

	// Startup selector field: bit 3 asks for automatic Operational.
	localparam int STARTUP_AUTO_OPER_BIT = 3;

	// Bit-rate codes.
	localparam logic [7:0] RATE_CODE_10K = 8'h81;
	localparam logic [7:0] RATE_CODE_20K = 8'h82;
	localparam logic [7:0] RATE_CODE_50K = 8'h83;
	localparam logic [7:0] RATE_CODE_125K = 8'h84;
	localparam logic [7:0] RATE_CODE_250K = 8'h85;
	localparam logic [7:0] RATE_CODE_500K = 8'h86;
	localparam logic [7:0] RATE_CODE_1000K = 8'h88;

	// Bit rates in kBd, as carried on the rate output.
	localparam int KBD_WIDTH = 11;
	localparam logic [10:0] KBD_10 = 11'h00a;
	localparam logic [10:0] KBD_20 = 11'h014;
	localparam logic [10:0] KBD_50 = 11'h032;
	localparam logic [10:0] KBD_125 = 11'h07d;
	localparam logic [10:0] KBD_250 = 11'h0fa;
	localparam logic [10:0] KBD_500 = 11'h1f4;
	localparam logic [10:0] KBD_1000 = 11'h3e8;

	// Network-management state as seen by the rest of the controller.
	typedef enum logic [1:0] {
		NMT_INIT,
		NMT_PRE_OPERATIONAL,
		NMT_OPERATIONAL
	} nmt_state_type;

	// One object-dictionary access from the protocol engine.
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] index;
		logic [7:0] subindex;
		logic [31:0] wdata;
	} od_req_type;

	// Answer to an access, shown for one cycle.
	typedef struct packed {
		logic ack;
		logic abort;
		logic [31:0] rdata;
	} od_rsp_type;

endpackage

// ---- tb/canopen_cfg_bank_bench.sv ----
// Self-checking bench for the configuration bank.
// Assumes the master model drives the object port; other inputs come from here.
`timescale 1ns/1ns
`default_nettype none

module canopen_cfg_bank_bench;
	logic clk_i;
	logic rst_n_i;
	canopen_cfg_pkg::od_req_type req;
	canopen_cfg_pkg::od_rsp_type rsp;
	logic sb_ld, sc_ld, init_done, reinit;
	logic [31:0] sb_d, sc_d, startup, rd;
	logic [7:0] ctrl_b, ctrl_s, code;
	logic [10:0] kbd;
	logic listed, ab;
	canopen_cfg_pkg::nmt_state_type nmt;
	int error_cnt = 0;
	int comparisons = 0;
	canopen_cfg_bank canopen_cfg_bank_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
		.rsp_o(rsp), .status_boot_load_i(sb_ld), .status_boot_i(sb_d),
		.status_script_load_i(sc_ld), .status_script_i(sc_d), .init_done_i(init_done),
		.reinit_i(reinit), .prog_ctrl_boot_o(ctrl_b), .prog_ctrl_script_o(ctrl_s),
		.startup_select_o(startup), .nmt_state_o(nmt), .bit_rate_code_o(code),
		.bit_rate_kbd_o(kbd), .bit_rate_listed_o(listed));
	od_master_model od_master_model_inst (.clk_i(clk_i), .req_o(req), .rsp_i(rsp));
	// 50 MHz clock.
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Compare and report.
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic wr, input logic [23:0] obj, input logic [31:0] wd);
		od_master_model_inst.access(wr, obj, wd, rd, ab);
	endtask
	// One-cycle pulse on a control input.
	task automatic pulse(ref logic s);
		@(posedge clk_i);
		#1;
		s = 1'b1;
		@(posedge clk_i);
		#1;
		s = 1'b0;
	endtask
	// Every object reads its preset value.
	task automatic test_reset();
		logic [23:0] obj[8] = '{24'h1f5100, 24'h1f5101, 24'h1f5102, 24'h1f5700, 24'h1f5701,
			24'h1f5702, 24'h1f8000, 24'h200500};
		logic [31:0] exp[8] = '{32'h2, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0, 32'h88};
		for (int k = 0; k < 8; k++)
		begin
			acc(1'b0, obj[k], 32'h0);
			check("preset", rd, exp[k]);
		end
		check("kbd", {21'h0, kbd}, 32'h3e8);
		$display("test_reset done");
	endtask
	// Writes store low bytes; refused writes leave values alone.
	task automatic test_access();
		logic [23:0] ro[6] = '{24'h1f5100, 24'h1f5700, 24'h1f5701, 24'h1f5702, 24'h200501,
			24'h200600};
		logic [31:0] exp[6] = '{32'h2, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0};
		acc(1'b1, 24'h1f5101, 32'hffff_ffa5);
		check("boot ctrl", {24'h0, ctrl_b}, 32'ha5);
		check("old value", rd, 32'h0);
		check("write taken", {31'h0, ab}, 32'h0);
		acc(1'b1, 24'h1f5102, 32'h5a);
		check("script ctrl out", {24'h0, ctrl_s}, 32'h5a);
		acc(1'b0, 24'h1f5102, 32'h0);
		check("script ctrl", rd, 32'h5a);
		for (int k = 0; k < 6; k++)
		begin
			acc(1'b1, ro[k], 32'hffff_ffff);
			check("refused", {31'h0, ab}, 32'h1);
			acc(1'b0, ro[k], 32'h0);
			check("unchanged", rd, exp[k]);
		end
		$display("test_access done");
	endtask
	// Status words follow the programming engine.
	task automatic test_status();
		sb_d = 32'h1234_5678;
		sc_d = 32'h00ab_cdef;
		pulse(sb_ld);
		pulse(sc_ld);
		acc(1'b0, 24'h1f5701, 32'h0);
		check("boot status", rd, 32'h1234_5678);
		acc(1'b0, 24'h1f5702, 32'h0);
		check("script status", rd, 32'h00ab_cdef);
		$display("test_status done");
	endtask
	// Every code from 81 to 88, the unlisted 87 among them.
	task automatic test_rate();
		logic [10:0] exp[8] = '{11'h00a, 11'h014, 11'h032, 11'h07d, 11'h0fa, 11'h1f4, 11'h3e8,
			11'h3e8};
		for (int k = 0; k < 8; k++)
		begin
			acc(1'b1, 24'h200500, 32'h81 + k);
			check("code out", {24'h0, code}, 32'h81 + k);
			@(posedge clk_i);
			#1;
			check("kbd", {21'h0, kbd}, {21'h0, exp[k]});
			check("listed", {31'h0, listed}, (k == 6) ? 32'h0 : 32'h1);
			acc(1'b0, 24'h200500, 32'h0);
			check("code", rd, 32'h81 + k);
		end
		$display("test_rate done");
	endtask
	// Startup selector zero then bit 3.
	task automatic test_nmt();
		pulse(init_done);
		check("nmt pre", {30'h0, nmt}, 32'h1);
		pulse(reinit);
		check("nmt init", {30'h0, nmt}, 32'h0);
		acc(1'b1, 24'h1f8000, 32'h8);
		check("startup", startup, 32'h8);
		pulse(init_done);
		check("nmt oper", {30'h0, nmt}, 32'h2);
		$display("test_nmt done");
	endtask
	// A reset in mid-run brings every object back to its preset.
	task automatic test_mid_reset();
		acc(1'b1, 24'h200500, 32'h84);
		@(posedge clk_i);
		#1;
		rst_n_i = 1'b0;
		@(posedge clk_i);
		#1;
		check("nmt reset", {30'h0, nmt}, 32'h0);
		check("boot ctrl reset", {24'h0, ctrl_b}, 32'h0);
		check("startup reset", startup, 32'h0);
		check("code reset", {24'h0, code}, 32'h88);
		check("kbd reset", {21'h0, kbd}, 32'h3e8);
		rst_n_i = 1'b1;
		repeat (2) @(posedge clk_i);
		test_reset();
		$display("test_mid_reset done");
	endtask
	task automatic wrap_up();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
		begin
			$display("SIMULATION PASSED");
		end
		else
		begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Main sequence.
	initial
	begin
		{rst_n_i, sb_ld, sc_ld, init_done, reinit, sb_d, sc_d} = '0;
		repeat (6) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		repeat (2) @(posedge clk_i);
		test_reset();
		test_access();
		test_status();
		test_rate();
		test_nmt();
		test_mid_reset();
		wrap_up();
	end
	// The tests need well under a thousand cycles.
	initial
	begin
		repeat (5000) @(posedge clk_i);
		error_cnt++;
		wrap_up();
	end
endmodule // canopen_cfg_bank_bench

bind canopen_cfg_bank canopen_cfg_checker canopen_cfg_checker_inst (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .req_i(req_i), .rsp_o(rsp_o), .init_done_i(init_done_i),
	.prog_ctrl_boot_o(prog_ctrl_boot_o), .startup_select_o(startup_select_o),
	.nmt_state_o(nmt_state_o), .bit_rate_code_o(bit_rate_code_o),
	.bit_rate_kbd_o(bit_rate_kbd_o), .bit_rate_listed_o(bit_rate_listed_o));

`default_nettype wire

// ---- tb/canopen_cfg_checker.sv ----
// Assertion checker for the configuration bank, watching only its ports.
// Assumes one clock and the one-cycle answer timing of the object port.
`timescale 1ns/1ns
`default_nettype none

module canopen_cfg_checker
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Object port and its answer.
	input wire canopen_cfg_pkg::od_req_type req_i,
	input wire canopen_cfg_pkg::od_rsp_type rsp_o,
	// Startup handshake and settings.
	input wire logic init_done_i,
	input wire logic [7:0] prog_ctrl_boot_o,
	input wire logic [31:0] startup_select_o,
	input wire canopen_cfg_pkg::nmt_state_type nmt_state_o,
	input wire logic [7:0] bit_rate_code_o,
	input wire logic [10:0] bit_rate_kbd_o,
	input wire logic bit_rate_listed_o
);
	// Edges since release; bit 1 means the bank's own reset has gone.
	logic [1:0] up_reg;
	logic [1:0] up_next;
	// Saturate at three so the flag never wraps back to zero.
	always_comb
	begin
		up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
	end
	// Cleared with the same asynchronous reset the bank sees.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			up_reg <= 2'h0;
		end
		else
		begin
			up_reg <= up_next;
		end
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// A request that the bank takes, and a taken write to one object.
	sequence s_take;
		up_reg[1] && req_i.valid;
	endsequence
	sequence s_wr(i, s);
		s_take ##0 (req_i.write && req_i.index == i && req_i.subindex == s);
	endsequence
	property p_ack;
		s_take |=> rsp_o.ack;
	endproperty
	a_ack: assert property (p_ack) else $error("no answer after a request");
	property p_ctrl_wr;
		s_wr(16'h1f51, 8'h01) |=> !rsp_o.abort && prog_ctrl_boot_o == $past(req_i.wdata[7:0]);
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr) else $error("boot control byte not stored");
	property p_cnt_ro;
		s_wr(16'h1f51, 8'h00) |=> rsp_o.abort && rsp_o.rdata == 32'h0000_0002;
	endproperty
	a_cnt_ro: assert property (p_cnt_ro) else $error("count write not refused");
	property p_stat_ro;
		s_take ##0 (req_i.write && req_i.index == 16'h1f57) |=> rsp_o.abort;
	endproperty
	a_stat_ro: assert property (p_stat_ro) else $error("status write not refused");
	property p_start_wr;
		s_wr(16'h1f80, 8'h00) |=> startup_select_o == $past(req_i.wdata);
	endproperty
	a_start_wr: assert property (p_start_wr) else $error("startup selector not stored");
	property p_pre;
		up_reg[1] && nmt_state_o == canopen_cfg_pkg::NMT_INIT && init_done_i
			&& !startup_select_o[3] |=> nmt_state_o == canopen_cfg_pkg::NMT_PRE_OPERATIONAL;
	endproperty
	a_pre: assert property (p_pre) else $error("startup did not stop short");
	property p_oper;
		up_reg[1] && nmt_state_o == canopen_cfg_pkg::NMT_INIT && init_done_i
			&& startup_select_o[3] |=> nmt_state_o == canopen_cfg_pkg::NMT_OPERATIONAL;
	endproperty
	a_oper: assert property (p_oper) else $error("startup did not go operational");
	property p_listed;
		bit_rate_listed_o == ($past(bit_rate_code_o) inside {[8'h81:8'h86], 8'h88});
	endproperty
	a_listed: assert property (p_listed) else $error("listed flag wrong");
	property p_unlisted;
		!bit_rate_listed_o |-> bit_rate_kbd_o == 11'h3e8;
	endproperty
	a_unlisted: assert property (p_unlisted) else $error("unlisted code not 1000");
	property p_kbd_125;
		$past(bit_rate_code_o) == 8'h84 |-> bit_rate_kbd_o == 11'h07d;
	endproperty
	a_kbd_125: assert property (p_kbd_125) else $error("code 84 not 125");
endmodule // canopen_cfg_checker

`default_nettype wire

// ---- tb/od_master_model.sv ----
// Behavioural bus master that issues object accesses to the bank.
// Assumes the answer stands in the cycle after the taking edge.
`timescale 1ns/1ns
`default_nettype none

module od_master_model
(
	// Clock.
	input wire logic clk_i,
	// Request out, answer in.
	output var canopen_cfg_pkg::od_req_type req_o,
	input wire canopen_cfg_pkg::od_rsp_type rsp_i
);
	// Idle from time zero.
	initial
	begin
		req_o = '0;
	end
	// One access: valid pulses one cycle, the answer is taken the cycle after.
	task automatic access(input logic wr, input logic [23:0] obj, input logic [31:0] wd,
		output logic [31:0] rd, output logic ab);
		@(posedge clk_i);
		#1;
		req_o = {1'b1, wr, obj, wd};
		@(posedge clk_i);
		#1;
		// Valid drops after one cycle; released data does not keep its last value.
		req_o = {1'b0, wr, obj, ~wd};
		rd = rsp_i.rdata;
		// A missing answer poisons the abort flag so the caller sees it.
		ab = (rsp_i.ack === 1'b1) ? rsp_i.abort : 1'bx;
	endtask
endmodule // od_master_model

`default_nettype wire
